// ===== iwr_pkg.sv
// iwr_pkg: constants shared by the two-wire wiper register slave.
// assumes a single core clock domain; scl and sda are sampled pins.
`default_nettype none

package iwr_pkg;

  localparam int unsigned IWR_ADDR_W = 7;
  localparam int unsigned IWR_WIPER_W = 7;
  localparam int unsigned IWR_BYTE_W = 8;
  localparam int unsigned IWR_CNT_W = 4;
  localparam logic [IWR_CNT_W-1:0] IWR_ACK_BIT = 4'h8;
  localparam logic [IWR_CNT_W-1:0] IWR_CNT_RST = 4'h0;
  localparam logic [IWR_ADDR_W-1:0] IWR_ADDR_DEFAULT = 7'h2e;
  localparam logic [IWR_WIPER_W-1:0] IWR_WIPER_RST = 7'h40;
  localparam logic [1:0] IWR_SYNC_RST = 2'h3;
  localparam logic IWR_DIR_WRITE = 1'b0;
  localparam logic IWR_DIR_READ = 1'b1;

  typedef enum logic [2:0] {
    IWR_IDLE,
    IWR_ADDR,
    IWR_ADDR_ACK,
    IWR_WR_DATA,
    IWR_WR_ACK,
    IWR_RD_DATA,
    IWR_RD_ACK
  } iwr_state_e;

endpackage : iwr_pkg

`default_nettype wire

// ===== iwr_pin_sync.sv
// iwr_pin_sync: two-flop synchroniser for one pin plus edge detection.
// assumes the pin is asynchronous to clk and idles high (pulled up bus).
`default_nettype none

module iwr_pin_sync
  import iwr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic pin_i, // raw pin level
  output logic level_o, // synchronised level
  output logic rise_o, // one-cycle pulse on rising edge
  output logic fall_o // one-cycle pulse on falling edge
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic prev_q;
  logic prev_d;

  always_comb begin
    sync_d = {sync_q[0], pin_i};
    prev_d = sync_q[1];
  end

  // only sync_q[1] feeds logic; the first stage is read by nothing else
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_q <= IWR_SYNC_RST;
      prev_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_o = sync_q[1];
  assign rise_o = sync_q[1] & ~prev_q;
  assign fall_o = ~sync_q[1] & prev_q;

endmodule // iwr_pin_sync

`default_nettype wire

// ===== iwr_shifter.sv
// iwr_shifter: eight-bit shift register with a bit counter for one byte.
// assumes sample and clear pulses come from the same core clock domain.
`default_nettype none

module iwr_shifter
  import iwr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clear_i, // restart the byte, drop partial bits
  input wire logic sample_i, // shift in one bit (scl rising)
  input wire logic bit_i, // bit to shift in
  input wire logic adv_i, // advance bit count (scl falling)
  output logic [iwr_pkg::IWR_BYTE_W-1:0] byte_o, // shifted byte, msb first
  output logic [iwr_pkg::IWR_CNT_W-1:0] cnt_o // bits completed in this slot
);

  logic [IWR_BYTE_W-1:0] sh_q;
  logic [IWR_BYTE_W-1:0] sh_d;
  logic [IWR_CNT_W-1:0] cnt_q;
  logic [IWR_CNT_W-1:0] cnt_d;

  always_comb begin
    sh_d = sh_q;
    cnt_d = cnt_q;
    if (clear_i) begin
      cnt_d = IWR_CNT_RST;
    end else begin
      if (sample_i && cnt_q < IWR_ACK_BIT) begin
        sh_d = {sh_q[IWR_BYTE_W-2:0], bit_i}; // msb arrives first
      end
      if (adv_i) begin
        cnt_d = (cnt_q == IWR_ACK_BIT) ? IWR_CNT_RST : cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sh_q <= '0;
      cnt_q <= IWR_CNT_RST;
    end else begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
    end
  end

  assign byte_o = sh_q;
  assign cnt_o = cnt_q;

endmodule // iwr_shifter

`default_nettype wire

// ===== iwr_wiper_slave.sv
// iwr_wiper_slave: two-wire bus slave holding the 7-bit wiper register.
// assumes scl and sda come from pins with an external pull-up; the core clock
// runs well above scl so every scl edge is seen after synchronisation.
// each scl phase must last at least four core cycles; the wiper is a plain
// register, so a loss of power brings it back to midscale.
`default_nettype none

module iwr_wiper_slave
  import iwr_pkg::*;
#(
  parameter logic [iwr_pkg::IWR_ADDR_W-1:0] BUS_ADDR = iwr_pkg::IWR_ADDR_DEFAULT // fixed address
)
(
  input wire logic core_clk, // core clock, 250 mhz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe, // high while pulling sda low
  output logic [iwr_pkg::IWR_WIPER_W-1:0] wiper_o, // wiper code to the ladder
  output logic wiper_upd_o // one-cycle pulse when wiper is loaded
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus conditions

  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  logic start_ev;
  logic stop_ev;

  iwr_pin_sync u_scl_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );

  iwr_pin_sync u_sda_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_i(sda_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  // sda edges while scl is high are conditions, never data
  assign start_ev = sda_fall & scl_lvl;
  assign stop_ev = sda_rise & scl_lvl;

  //////////////////////////////////////////////////////////////////////////
  // byte shifter

  logic [IWR_BYTE_W-1:0] rx_byte;
  logic [IWR_CNT_W-1:0] bit_cnt;
  iwr_state_e state_q;
  iwr_state_e state_d;
  logic shift_clear;

  // a start or stop restarts the bit count, so partial bytes vanish
  assign shift_clear = start_ev | stop_ev | (state_q == IWR_IDLE);

  logic lead_q;
  logic lead_d;
  logic shift_adv;

  // the scl fall that closes a start has no rising edge before it, so it
  // must not count as a bit, or the address would land one bit early
  always_comb begin
    lead_d = lead_q;
    if (start_ev) begin
      lead_d = 1'b1;
    end else if (stop_ev || scl_fall) begin
      lead_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lead_q <= 1'b0;
    end else begin
      lead_q <= lead_d;
    end
  end

  assign shift_adv = scl_fall & ~lead_q;

  iwr_shifter u_shifter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear_i(shift_clear),
    .sample_i(scl_rise),
    .bit_i(sda_lvl),
    .adv_i(shift_adv),
    .byte_o(rx_byte),
    .cnt_o(bit_cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // protocol state machine

  logic byte_done;
  logic addr_hit;
  logic [IWR_WIPER_W-1:0] wiper_q;
  logic [IWR_WIPER_W-1:0] wiper_d;
  logic upd_q;
  logic upd_d;
  logic [IWR_BYTE_W-1:0] tx_q;
  logic [IWR_BYTE_W-1:0] tx_d;
  logic drive_q;
  logic drive_d;
  logic master_ack;

  // the eighth scl falling edge closes the data bits of a byte
  assign byte_done = scl_fall & (bit_cnt == IWR_ACK_BIT - 4'h1);
  logic [IWR_ADDR_W-1:0] addr_bit_ok;
  // one comparator per address bit; the direction bit sits below them
  for (genvar g = 0; g < IWR_ADDR_W; g++) begin : g_addr
    assign addr_bit_ok[g] = (rx_byte[g+1] == BUS_ADDR[g]);
  end
  assign addr_hit = &addr_bit_ok;
  // master ack sampled at the ninth rising edge: low means continue
  assign master_ack = ~sda_lvl;

  logic tx_load;
  logic tx_shift;
  logic wr_load;
  logic dir_q;
  logic dir_d;

  // direction latched with the address so nothing in the ack slot can disturb it
  always_comb begin
    dir_d = dir_q;
    if (state_q == IWR_ADDR && byte_done) begin
      dir_d = rx_byte[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dir_q <= IWR_DIR_WRITE;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_comb begin
    state_d = state_q;
    wr_load = 1'b0;
    tx_load = 1'b0;
    tx_shift = 1'b0;
    drive_d = drive_q;
    if (start_ev) begin
      state_d = IWR_ADDR;
      drive_d = 1'b0;
    end else if (stop_ev) begin
      state_d = IWR_IDLE;
      drive_d = 1'b0;
    end else begin
      unique case (state_q)
        IWR_IDLE: begin
          drive_d = 1'b0;
        end
        IWR_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              state_d = IWR_ADDR_ACK;
              drive_d = 1'b1;
            end else begin
              state_d = IWR_IDLE;
            end
          end
        end
        IWR_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_q == IWR_DIR_READ) begin
              state_d = IWR_RD_DATA;
              tx_load = 1'b1;
              drive_d = 1'b1; // a read byte always opens with a zero
            end else begin
              state_d = IWR_WR_DATA;
              drive_d = 1'b0;
            end
          end
        end
        IWR_WR_DATA: begin
          if (byte_done) begin
            wr_load = 1'b1;
            state_d = IWR_WR_ACK;
            drive_d = 1'b1;
          end
        end
        IWR_WR_ACK: begin
          if (scl_fall) begin
            state_d = IWR_WR_DATA;
            drive_d = 1'b0;
          end
        end
        IWR_RD_DATA: begin
          // drive the next bit on each falling edge, held while scl high
          if (scl_fall) begin
            if (bit_cnt == IWR_ACK_BIT - 4'h1) begin
              state_d = IWR_RD_ACK;
              drive_d = 1'b0;
            end else begin
              tx_shift = 1'b1;
              drive_d = ~tx_q[IWR_BYTE_W-2];
            end
          end
        end
        IWR_RD_ACK: begin
          if (scl_rise && !master_ack) begin
            state_d = IWR_IDLE;
          end else if (scl_fall) begin
            state_d = IWR_RD_DATA;
            tx_load = 1'b1;
            drive_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= IWR_IDLE;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      drive_q <= drive_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read-back byte: loaded with the wiper for each read byte, shifted per bit

  always_comb begin
    tx_d = tx_q;
    if (tx_load) begin
      tx_d = {1'b0, wiper_q};
    end else if (tx_shift) begin
      tx_d = {tx_q[IWR_BYTE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wiper register: loads only on a whole data byte, so a cut byte never lands

  always_comb begin
    wiper_d = wiper_q;
    upd_d = 1'b0;
    if (wr_load) begin
      wiper_d = rx_byte[IWR_WIPER_W-1:0];
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wiper_q <= IWR_WIPER_RST;
      upd_q <= 1'b0;
    end else begin
      wiper_q <= wiper_d;
      upd_q <= upd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs: open-drain, so only a low is ever driven

  assign sda_o = 1'b0;
  assign sda_oe = drive_q;
  assign wiper_o = wiper_q;
  assign wiper_upd_o = upd_q;

endmodule // iwr_wiper_slave

`default_nettype wire

// ===== iwr_wiper_slave_chk.sv
// iwr_wiper_slave_chk: port assertions for the two-wire wiper slave.
// assumes sda_i is the resolved wire with a pull-up and scl is slow.
`default_nettype none

module iwr_wiper_slave_chk
  import iwr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // sync reset
  input wire logic scl_i, // bus clock pin
  input wire logic sda_i, // bus data wire
  input wire logic sda_o, // drive value
  input wire logic sda_oe, // drive enable
  input wire logic [iwr_pkg::IWR_WIPER_W-1:0] wiper_o, // wiper code
  input wire logic wiper_upd_o // load pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_start; scl_i && $fell(sda_i); endsequence
  sequence s_stop; scl_i && $rose(sda_i); endsequence
  property p_rst; disable iff (1'b0)
    sys_rst |=> wiper_o == IWR_WIPER_RST && !sda_oe && !wiper_upd_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold; scl_i |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("sda moved with scl high");
  property p_ack; $rose(sda_oe) |-> ##[1:8] ($rose(scl_i) && sda_oe && !sda_o); endproperty
  a_ack: assert property (p_ack) else $error("drive not held into slot");
  property p_upd; $changed(wiper_o) |-> wiper_upd_o; endproperty
  a_upd: assert property (p_upd) else $error("wiper moved without pulse");
  property p_pulse; wiper_upd_o |=> !wiper_upd_o; endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
  property p_updlow; wiper_upd_o |-> !scl_i; endproperty
  a_updlow: assert property (p_updlow) else $error("load outside bit end");
  property p_stop; s_stop |=> !sda_oe [*8]; endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
  property p_start; s_start |=> !sda_oe [*8]; endproperty
  a_start: assert property (p_start) else $error("drive after start");
endmodule // iwr_wiper_slave_chk

bind iwr_wiper_slave iwr_wiper_slave_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wiper_o(wiper_o),
  .wiper_upd_o(wiper_upd_o));

`default_nettype wire

// ===== iwr_bus_master.sv
// iwr_bus_master: behavioural two-wire bus master, 48 ns bit period.
// assumes an external pull-up on sda; scl stands high outside frames.
`default_nettype none

module iwr_bus_master (
  input wire logic sda_i, // resolved data wire
  output logic scl_o, // bus clock
  output logic sda_low_o // high while pulling sda low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task start;
    sda_low_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 sda_low_o = 1'b1;
    #12 scl_o = 1'b0;
    #12;
  endtask
  task stop;
    sda_low_o = 1'b1;
    #12 scl_o = 1'b1;
    #12 sda_low_o = 1'b0;
    #24;
  endtask
  // msb first from d[8]; sda only moves while scl is low
  task xfer(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h000;
    for (int i = 0; i < n; i++) begin
      sda_low_o = !d[8-i];
      #12 scl_o = 1'b1;
      #12 q[8-i] = sda_i;
      #12 scl_o = 1'b0;
      #12;
    end
  endtask
endmodule // iwr_bus_master

`default_nettype wire

// ===== iwr_wiper_slave_tb.sv
// iwr_wiper_slave_tb: self-checking bench for the two-wire wiper slave.
// assumes the bus master model and checker are compiled first.
`default_nettype none

module iwr_wiper_slave_tb;
  import iwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda_o, sda_oe, wiper_upd;
  logic [IWR_WIPER_W-1:0] wiper;
  logic [8:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int n_upd = 0;
  wire logic sda = !(sda_low || (sda_oe && !sda_o));
  always #2 core_clk = ~core_clk;
  // load pulses are counted half a cycle after they launch, once settled
  always @(negedge core_clk) begin
    if (wiper_upd === 1'b1) begin
      n_upd++;
    end
  end
  iwr_bus_master i_mst (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  iwr_wiper_slave i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .wiper_o(wiper), .wiper_upd_o(wiper_upd));
  ////////////////////////////////////////////////////////////////////////
  task chk(string nm, logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task addr(logic [6:0] a, logic dir, logic nak);
    @(posedge core_clk) #1;
    i_mst.start();
    i_mst.xfer({a, dir, 1'b1}, 9, q);
    chk("addr ack", q[0], nak);
  endtask
  task t_write;
    logic [7:0] d [3];
    d = '{8'hff, 8'h00, 8'hd3};
    addr(IWR_ADDR_DEFAULT, IWR_DIR_WRITE, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_mst.xfer({d[i], 1'b1}, 9, q);
      chk("data ack", q[0], 1'b0);
      chk("wiper", wiper, d[i][6:0]);
    end
    i_mst.stop();
    chk("updates", n_upd[8:0], 9'h003);
  endtask
  task t_read;
    addr(IWR_ADDR_DEFAULT, IWR_DIR_READ, 1'b0);
    for (int i = 0; i < 2; i++) begin
      i_mst.xfer({8'hff, i == 1}, 9, q);
      chk("read data", q[8:1], 8'h53);
    end
    i_mst.stop();
  endtask
  task t_miss;
    addr(7'h2f, IWR_DIR_WRITE, 1'b1);
    i_mst.xfer({8'h11, 1'b1}, 9, q);
    chk("no ack", q[0], 1'b1);
    i_mst.stop();
    chk("wiper kept", wiper, 7'h53);
    chk("no load", n_upd[8:0], 9'h003);
  endtask
  task t_partial;
    addr(IWR_ADDR_DEFAULT, IWR_DIR_WRITE, 1'b0);
    i_mst.xfer({8'h0a, 1'b1}, 4, q);
    i_mst.stop();
    chk("stop drop", wiper, 7'h53);
    addr(IWR_ADDR_DEFAULT, IWR_DIR_WRITE, 1'b0);
    i_mst.xfer({8'h6c, 1'b1}, 5, q);
    addr(IWR_ADDR_DEFAULT, IWR_DIR_WRITE, 1'b0);
    chk("start drop", wiper, 7'h53);
    i_mst.xfer({8'h21, 1'b1}, 9, q);
    i_mst.stop();
    chk("wiper", wiper, 7'h21);
    chk("updates", n_upd[8:0], 9'h004);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk("reset wiper", wiper, IWR_WIPER_RST);
    chk("reset drive", sda_oe, 1'b0);
    repeat (3) @(posedge core_clk);
    t_write();
    t_read();
    t_miss();
    t_partial();
    report_and_stop();
  end
  // whole run is about 6.6 us of bus traffic
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule // iwr_wiper_slave_tb

`default_nettype wire
